// >>> hw/tkcss_map.vh
// Constants for the touch key confirmation, sleep and self-test block.
`ifndef TKCSS_MAP_VH
`define TKCSS_MAP_VH

// Matrix size and field widths.
`define TKCSS_NKEYS      24
`define TKCSS_KEY_W      5
`define TKCSS_LIM_W      4
`define TKCSS_LVL_W      16
`define TKCSS_IVL_W      16
`define TKCSS_TICK_W     16

// Counter reset values.
`define TKCSS_CNT_RST    4'h0

// Sleep timing: one sleep interval unit is 1 ms of the 100 ns clock.
`define TKCSS_CLK_NS     100
`define TKCSS_TICK_NS    1000000
`define TKCSS_TICK_CYC   (`TKCSS_TICK_NS / `TKCSS_CLK_NS)

// Read map, one byte per address.
`define TKCSS_RD_TOUCH0  4'h0
`define TKCSS_RD_FAULT0  4'h3
`define TKCSS_RD_LSL0    4'h6
`define TKCSS_RD_STATUS  4'h9

// Status byte field positions.
`define TKCSS_ST_FMEA    0
`define TKCSS_ST_LSL     1
`define TKCSS_ST_SLEEP   2
`define TKCSS_ST_TOUCH   3

// Read check sum: CRC-8 polynomial and seed.
`define TKCSS_CRC_POLY   8'h07
`define TKCSS_CRC_INIT   8'hFF

`endif

// >>> hw/tkcss_top.v
// Touch key confirmation, sleep scheduling and self-test slot logic.
`timescale 1ns/1ps
`include "tkcss_map.vh"

module tkcss_top #(
  parameter SLEEP_TICK_CYC = `TKCSS_TICK_CYC
) (
  input  wire         clk_sys,
  input  wire         rst_n,
  input  wire         clk_en,
  input  wire [23:0]  key_enable,
  input  wire [95:0]  fast_limit,
  input  wire [95:0]  outer_limit,
  input  wire         sleep_enable,
  input  wire [15:0]  sleep_interval,
  input  wire [15:0]  low_signal_limit,
  input  wire [15:0]  key_gain_test_threshold,
  input  wire [23:0]  key_calibrating,
  input  wire         acq_done,
  input  wire         acq_above,
  input  wire [15:0]  acq_level,
  input  wire         acq_fault,
  input  wire         comm_start,
  input  wire         comm_active,
  input  wire         rd_req,
  input  wire         rd_first,
  input  wire [3:0]   rd_addr,
  output reg          acq_req_q,
  output reg  [4:0]   acq_key_q,
  output reg          acq_test_q,
  output reg  [23:0]  touched_q,
  output reg  [23:0]  fault_q,
  output reg  [23:0]  lsl_q,
  output reg          fmea_err_q,
  output reg          lsl_err_q,
  output reg          asleep_q,
  output reg          drift_run_q,
  output reg          rd_valid_q,
  output reg  [7:0]   rd_data_q,
  output reg  [7:0]   rd_crc_q
);

  // Scan sequencer states, one binary code each.
  localparam [2:0] ST_START = 3'd0;
  localparam [2:0] ST_KEY   = 3'd1;
  localparam [2:0] ST_WAIT  = 3'd2;
  localparam [2:0] ST_TSEL  = 3'd3;
  localparam [2:0] ST_TWAIT = 3'd4;
  localparam [2:0] ST_END   = 3'd5;
  localparam [2:0] ST_SLEEP = 3'd6;
  localparam [4:0] KEY_LAST = 5'd23;
  localparam [4:0] KEY_END  = 5'd24;

  // Last clock of one sleep tick, cut to the tick counter's width on purpose.
  localparam integer TICK_LAST_I = SLEEP_TICK_CYC - 1;
  localparam [15:0]  TICK_LAST   = TICK_LAST_I[15:0];

  // Sequencer, sleep timer, read CRC and per-key counter storage.
  reg  [2:0]   state_q;
  reg  [4:0]   key_q;
  reg  [4:0]   tkey_q;
  reg  [4:0]   tries_q;
  reg          scan_touch_q;
  reg  [15:0]  tick_q;
  reg  [15:0]  ivl_q;
  reg  [7:0]   crc_q;
  reg  [3:0]   inner_q [0:23];
  reg  [3:0]   outer_q [0:23];

  // Values built by the combinational processes below.
  reg  [3:0]   flim;
  reg  [3:0]   olim;
  reg  [3:0]   inner_c;
  reg  [3:0]   outer_c;
  reg  [4:0]   inner_inc;
  reg          sleep_ok;
  reg  [7:0]   rd_byte;
  integer      i;

  //////////////////////////////////////////////////////////////////////////
  // Helpers.

  // One byte step of the read CRC, MSB first.
  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer     b;
    reg   [7:0] r;
    begin
      r = c ^ d;
      for (b = 0; b < 8; b = b + 1) begin
        if (r[7]) begin
          r = {r[6:0], 1'b0} ^ `TKCSS_CRC_POLY;
        end else begin
          r = {r[6:0], 1'b0};
        end
      end
      crc8 = r;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Combinational selection of the current key's limits and counters.

  // Limits are 4-bit fields packed low key first.
  always @* begin
    flim      = fast_limit[key_q*4 +: 4];
    olim      = outer_limit[key_q*4 +: 4];
    inner_c   = inner_q[key_q];
    outer_c   = outer_q[key_q];
    inner_inc = {1'b0, inner_c} + 5'd1;
  end

  // Sleep is allowed only when nothing at all asks for attention.
  always @* begin
    sleep_ok = sleep_enable
             & ~|key_calibrating
             & ~scan_touch_q
             & ~comm_active
             & ~comm_start;
  end

  // Read byte selection; unmapped addresses read as zero.
  always @* begin
    case (rd_addr)
      `TKCSS_RD_TOUCH0:       rd_byte = touched_q[7:0];
      `TKCSS_RD_TOUCH0 + 4'h1: rd_byte = touched_q[15:8];
      `TKCSS_RD_TOUCH0 + 4'h2: rd_byte = touched_q[23:16];
      `TKCSS_RD_FAULT0:       rd_byte = fault_q[7:0];
      `TKCSS_RD_FAULT0 + 4'h1: rd_byte = fault_q[15:8];
      `TKCSS_RD_FAULT0 + 4'h2: rd_byte = fault_q[23:16];
      `TKCSS_RD_LSL0:         rd_byte = lsl_q[7:0];
      `TKCSS_RD_LSL0 + 4'h1:   rd_byte = lsl_q[15:8];
      `TKCSS_RD_LSL0 + 4'h2:   rd_byte = lsl_q[23:16];
      `TKCSS_RD_STATUS: begin
        rd_byte = 8'h00;
        rd_byte[`TKCSS_ST_FMEA]  = fmea_err_q;
        rd_byte[`TKCSS_ST_LSL]   = lsl_err_q;
        rd_byte[`TKCSS_ST_SLEEP] = asleep_q;
        rd_byte[`TKCSS_ST_TOUCH] = |touched_q;
      end
      default:                rd_byte = 8'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Scan sequencer, confirmation counters, self-test slot and sleep.

  // All state freezes while clk_en is low.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q      <= ST_START;
      key_q        <= 5'd0;
      tkey_q       <= 5'd0;
      tries_q      <= 5'd0;
      scan_touch_q <= 1'b0;
      tick_q       <= 16'h0000;
      ivl_q        <= 16'h0000;
      acq_req_q    <= 1'b0;
      acq_key_q    <= 5'd0;
      acq_test_q   <= 1'b0;
      touched_q    <= 24'h000000;
      fault_q      <= 24'h000000;
      lsl_q        <= 24'h000000;
      fmea_err_q   <= 1'b0;
      lsl_err_q    <= 1'b0;
      asleep_q     <= 1'b0;
      drift_run_q  <= 1'b0;
      for (i = 0; i < 24; i = i + 1) begin
        inner_q[i] <= `TKCSS_CNT_RST;
        outer_q[i] <= `TKCSS_CNT_RST;
      end
    end else if (clk_en) begin
      acq_req_q   <= 1'b0;
      fmea_err_q  <= |fault_q;
      lsl_err_q   <= |lsl_q;
      drift_run_q <= ~asleep_q;
      case (state_q)
        // Start a new matrix scan from the first key.
        ST_START: begin
          key_q        <= 5'd0;
          scan_touch_q <= 1'b0;
          state_q      <= ST_KEY;
        end
        // Issue a burst for an enabled key; skip and clear disabled ones.
        ST_KEY: begin
          if (key_q == KEY_END) begin
            tries_q <= 5'd0;
            state_q <= ST_TSEL;
          end else if (!key_enable[key_q]) begin
            inner_q[key_q]   <= `TKCSS_CNT_RST;
            outer_q[key_q]   <= `TKCSS_CNT_RST;
            touched_q[key_q] <= 1'b0;
            key_q            <= key_q + 5'd1;
          end else begin
            acq_req_q  <= 1'b1;
            acq_key_q  <= key_q;
            acq_test_q <= 1'b0;
            state_q    <= ST_WAIT;
          end
        end
        // Apply the result of one burst to the two-tier counters.
        ST_WAIT: begin
          if (acq_done) begin
            lsl_q[key_q] <= acq_level < low_signal_limit;
            if (acq_above) begin
              scan_touch_q <= 1'b1;
              if (inner_inc >= {1'b0, flim}) begin
                inner_q[key_q] <= `TKCSS_CNT_RST;
                key_q          <= key_q + 5'd1;
                if (outer_c < olim) begin
                  outer_q[key_q]   <= outer_c + 4'd1;
                  touched_q[key_q] <= (outer_c + 4'd1) >= olim;
                end else begin
                  touched_q[key_q] <= 1'b1;
                end
              end else begin
                inner_q[key_q] <= inner_inc[3:0];
              end
            end else begin
              // Below threshold: both counters step down, scan moves on.
              if (inner_c != 4'd0) begin
                inner_q[key_q] <= inner_c - 4'd1;
              end
              if (outer_c != 4'd0) begin
                outer_q[key_q]   <= outer_c - 4'd1;
                touched_q[key_q] <= (outer_c - 4'd1) >= olim;
              end else begin
                touched_q[key_q] <= olim == 4'd0;
              end
              key_q <= key_q + 5'd1;
            end
            state_q <= ST_KEY;
          end
        end
        // Pick the next enabled key for the self-test slot.
        ST_TSEL: begin
          if (key_enable[tkey_q]) begin
            acq_req_q  <= 1'b1;
            acq_key_q  <= tkey_q;
            acq_test_q <= 1'b1;
            state_q    <= ST_TWAIT;
          end else if (tries_q == KEY_LAST) begin
            state_q <= ST_END;
          end else begin
            tries_q <= tries_q + 5'd1;
            tkey_q  <= (tkey_q == KEY_LAST) ? 5'd0 : tkey_q + 5'd1;
          end
        end
        // Record the self-test outcome for the tested key.
        ST_TWAIT: begin
          if (acq_done) begin
            fault_q[tkey_q] <= acq_fault
                             | (acq_level < key_gain_test_threshold);
            tkey_q  <= (tkey_q == KEY_LAST) ? 5'd0 : tkey_q + 5'd1;
            state_q <= ST_END;
          end
        end
        // End of scan: drop flags of disabled keys and decide on sleep.
        ST_END: begin
          fault_q <= fault_q & key_enable;
          lsl_q   <= lsl_q & key_enable;
          tick_q  <= 16'h0000;
          ivl_q   <= 16'h0000;
          if (sleep_ok) begin
            asleep_q <= 1'b1;
            state_q  <= ST_SLEEP;
          end else begin
            state_q  <= ST_START;
          end
        end
        // Halted; wake on interval expiry, serial traffic or sleep off.
        ST_SLEEP: begin
          if (comm_start || !sleep_enable) begin
            asleep_q <= 1'b0;
            state_q  <= ST_START;
          end else if (tick_q == TICK_LAST) begin
            // One tick has passed; count it toward the sleep interval.
            tick_q <= 16'h0000;
            ivl_q  <= ivl_q + 16'h0001;
            if (ivl_q + 16'h0001 >= sleep_interval) begin
              asleep_q <= 1'b0;
              state_q  <= ST_START;
            end
          end else begin
            tick_q <= tick_q + 16'h0001;
          end
        end
        default: begin
          state_q <= ST_START;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Host read port with running CRC over each read transfer.

  // The CRC restarts on the first byte of a transfer.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_q <= 1'b0;
      rd_data_q  <= 8'h00;
      rd_crc_q   <= 8'h00;
      crc_q      <= `TKCSS_CRC_INIT;
    end else if (clk_en) begin
      rd_valid_q <= rd_req;
      if (rd_req) begin
        rd_data_q <= rd_byte;
        if (rd_first) begin
          crc_q    <= crc8(`TKCSS_CRC_INIT, rd_byte);
          rd_crc_q <= crc8(`TKCSS_CRC_INIT, rd_byte);
        end else begin
          crc_q    <= crc8(crc_q, rd_byte);
          rd_crc_q <= crc8(crc_q, rd_byte);
        end
      end
    end
  end

endmodule // tkcss_top

// >>> test/tkcss_assertions.sv
// Concurrent checks on the scan, sleep and read ports of the block.
`timescale 1ns/1ps
module tkcss_assertions #(
  parameter SLEEP_TICK_CYC = 4
) (
  input wire        clk_sys,
  input wire        rst_n,
  input wire        clk_en,
  input wire [23:0] key_enable,
  input wire        sleep_enable,
  input wire [23:0] key_calibrating,
  input wire        comm_start,
  input wire        comm_active,
  input wire        rd_req,
  input wire        acq_req_q,
  input wire [4:0]  acq_key_q,
  input wire        acq_test_q,
  input wire [23:0] fault_q,
  input wire [23:0] lsl_q,
  input wire        fmea_err_q,
  input wire        lsl_err_q,
  input wire        asleep_q,
  input wire        drift_run_q,
  input wire        rd_valid_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // A read request taken on an enabled edge.
  sequence s_rd;
    rd_req && clk_en;
  endsequence
  a_read_answer: assert property (s_rd |=> rd_valid_q)
    else $error("read not answered next cycle");
  a_read_pulse: assert property (clk_en && !rd_req |=> !rd_valid_q)
    else $error("read valid without request");
  a_fmea_follow: assert property (clk_en |=> fmea_err_q == $past(|fault_q))
    else $error("fault summary does not follow fault bits");
  a_lsl_follow: assert property (clk_en |=> lsl_err_q == $past(|lsl_q))
    else $error("low signal summary does not follow bits");
  a_sleep_off: assert property (clk_en && !sleep_enable |=> !asleep_q)
    else $error("asleep while sleep is disabled");
  a_wake_comm: assert property (clk_en && asleep_q && comm_start |=> !asleep_q)
    else $error("serial start did not wake");
  a_sleep_block: assert property ($rose(asleep_q) |->
    !$past(comm_active) && !$past(comm_start) &&
    $past(key_calibrating) == 24'h000000)
    else $error("slept while sleep was blocked");
  a_no_scan_asleep: assert property (asleep_q |-> !acq_req_q)
    else $error("burst requested while asleep");
  a_drift_halt: assert property (clk_en |=> drift_run_q == !$past(asleep_q))
    else $error("drift run not halted by sleep");
  a_req_single: assert property (acq_req_q && clk_en |=> !acq_req_q)
    else $error("burst request longer than one cycle");
  a_test_enabled: assert property (acq_req_q && acq_test_q |->
    key_enable[acq_key_q])
    else $error("self-test slot on a disabled key");
endmodule // tkcss_assertions

bind tkcss_top tkcss_assertions #(.SLEEP_TICK_CYC(SLEEP_TICK_CYC)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
  .key_enable(key_enable), .sleep_enable(sleep_enable),
  .key_calibrating(key_calibrating), .comm_start(comm_start),
  .comm_active(comm_active), .rd_req(rd_req), .acq_req_q(acq_req_q),
  .acq_key_q(acq_key_q), .acq_test_q(acq_test_q), .fault_q(fault_q),
  .lsl_q(lsl_q), .fmea_err_q(fmea_err_q), .lsl_err_q(lsl_err_q),
  .asleep_q(asleep_q), .drift_run_q(drift_run_q), .rd_valid_q(rd_valid_q)
);

// >>> test/tkcss_acq_model.sv
// Acquisition front end model that answers each burst request.
`timescale 1ns/1ps
module tkcss_acq_model (
  input  wire        clk_sys,
  input  wire        acq_req_q,
  input  wire [4:0]  acq_key_q,
  input  wire        acq_test_q,
  input  wire [23:0] above_mask,
  input  wire [15:0] level,
  input  wire        fault_in,
  output reg         acq_done,
  output reg         acq_above,
  output reg  [15:0] acq_level,
  output reg         acq_fault
);
  reg [23:0] mask_s;
  reg [15:0] level_s;
  reg        fault_s;
  // Bench stimulus is taken at the rising edge, so that bench changes on the
  // falling edge never race the answer given on that same falling edge.
  always @(posedge clk_sys) begin
    mask_s  <= above_mask;
    level_s <= level;
    fault_s <= fault_in;
  end
  initial begin
    acq_done = 1'b0;
    acq_above = 1'b0;
    acq_level = 16'h0000;
    acq_fault = 1'b0;
  end
  // Answer in the request cycle; between answers the lines toggle.
  always @(negedge clk_sys) begin
    acq_done <= acq_req_q;
    if (acq_req_q) begin
      acq_above <= mask_s[acq_key_q] & ~acq_test_q;
      acq_level <= level_s;
      acq_fault <= fault_s & acq_test_q;
    end else begin
      acq_above <= ~acq_above;
      acq_level <= ~acq_level;
      acq_fault <= ~acq_fault;
    end
  end
endmodule // tkcss_acq_model

// >>> test/testbench.sv
// Self-checking testbench for the touch confirmation block.
`timescale 1ns/1ps
module testbench;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg [23:0] key_enable = 24'h000003;
  reg [95:0] fast_limit = 96'h22;
  reg [95:0] outer_limit = 96'h33;
  reg sleep_enable = 1'b0;
  reg clk_en = 1'b1;
  reg [15:0] sleep_interval = 16'h0002;
  reg [23:0] key_calibrating = 24'h000000;
  reg comm_start = 1'b0, comm_active = 1'b0, rd_req = 1'b0, rd_first = 1'b0;
  reg [3:0] rd_addr = 4'h0;
  reg [23:0] above_mask = 24'h000001;
  reg [15:0] level = 16'h0200;
  reg fault_in = 1'b0;
  wire acq_done, acq_above, acq_fault, acq_req_q, acq_test_q;
  wire [15:0] acq_level;
  wire [4:0] acq_key_q;
  wire [23:0] touched_q, fault_q, lsl_q;
  wire fmea_err_q, lsl_err_q, asleep_q, drift_run_q, rd_valid_q;
  wire [7:0] rd_data_q, rd_crc_q;
  integer mismatches = 0, check_count = 0, bursts = 0, n, i;
  reg [7:0] crc;
  reg req_last_q = 1'b0;
  integer req_rises = 0, snap;
  always #50 clk_sys = ~clk_sys;
  tkcss_top #(.SLEEP_TICK_CYC(4)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en(clk_en), .key_enable(key_enable), .fast_limit(fast_limit),
    .outer_limit(outer_limit), .sleep_enable(sleep_enable),
    .sleep_interval(sleep_interval), .low_signal_limit(16'h0100),
    .key_gain_test_threshold(16'h0040), .key_calibrating(key_calibrating),
    .acq_done(acq_done), .acq_above(acq_above), .acq_level(acq_level),
    .acq_fault(acq_fault), .comm_start(comm_start),
    .comm_active(comm_active), .rd_req(rd_req), .rd_first(rd_first),
    .rd_addr(rd_addr), .acq_req_q(acq_req_q), .acq_key_q(acq_key_q),
    .acq_test_q(acq_test_q), .touched_q(touched_q), .fault_q(fault_q),
    .lsl_q(lsl_q), .fmea_err_q(fmea_err_q), .lsl_err_q(lsl_err_q),
    .asleep_q(asleep_q), .drift_run_q(drift_run_q),
    .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q), .rd_crc_q(rd_crc_q));
  tkcss_acq_model u_acq (.clk_sys(clk_sys), .acq_req_q(acq_req_q),
    .acq_key_q(acq_key_q), .acq_test_q(acq_test_q),
    .above_mask(above_mask), .level(level), .fault_in(fault_in),
    .acq_done(acq_done), .acq_above(acq_above), .acq_level(acq_level),
    .acq_fault(acq_fault));
  // Count normal bursts on key 0.
  always @(posedge clk_sys)
    if (acq_req_q && acq_key_q == 5'h00 && !acq_test_q) bursts <= bursts + 1;
  // Count rising edges of the burst request, any key or slot.
  always @(posedge clk_sys) begin
    req_last_q <= acq_req_q;
    if (acq_req_q === 1'b1 && req_last_q === 1'b0)
      req_rises <= req_rises + 1;
  end
  task chk_bit(input string name, input exp, input got);
    check_count = check_count + 1;
    if (got !== exp) begin
      $display("[FAIL] %0s expected %b seen %b", name, exp, got);
      mismatches = mismatches + 1;
    end
  endtask
  task chk_vec(input string name, input [23:0] exp, input [23:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      $display("[FAIL] %0s expected %h seen %h", name, exp, got);
      mismatches = mismatches + 1;
    end
  endtask
  function [7:0] crc8(input [7:0] c, input [7:0] d);
    c = c ^ d;
    for (i = 0; i < 8; i = i + 1) c = c[7] ? (c << 1) ^ 8'h07 : (c << 1);
    crc8 = c;
  endfunction
  // Waits for the next self-test slot request, which closes a scan.
  task wait_scan;
    n = 0;
    @(negedge clk_sys);
    while (!(acq_req_q && acq_test_q) && n < 400) begin
      @(negedge clk_sys);
      n = n + 1;
    end
    chk_bit("scan slot", 1'b1, acq_req_q && acq_test_q);
  endtask
  task wait_sleep;
    n = 0;
    while (asleep_q !== 1'b1 && n < 2000) begin
      @(negedge clk_sys);
      n = n + 1;
    end
    chk_bit("asleep", 1'b1, asleep_q);
  endtask
  // One byte read; the request stays up for a following read.
  task rd(input first, input [3:0] addr, input [7:0] exp);
    crc = crc8(first ? 8'hFF : crc, exp);
    rd_req = 1'b1;
    rd_first = first;
    rd_addr = addr;
    @(negedge clk_sys);
    chk_bit("rd_valid", 1'b1, rd_valid_q);
    chk_vec("rd_data", {16'h0, exp}, {16'h0, rd_data_q});
    chk_vec("rd_crc", {16'h0, crc}, {16'h0, rd_crc_q});
  endtask
  task t_confirm;
    n = 0;
    while (touched_q[0] !== 1'b1 && n < 3000) begin
      @(negedge clk_sys);
      n = n + 1;
    end
    chk_vec("bursts", 24'd6, bursts[23:0]);
    chk_vec("touched", 24'h000001, touched_q);
  endtask
  task t_read;
    rd(1'b1, 4'h0, 8'h01);
    rd(1'b0, 4'h9, 8'h08);
    rd(1'b0, 4'hF, 8'h00);
    rd_req = 1'b0;
    above_mask = 24'h000000;
    repeat (2) wait_scan;
    chk_vec("touched", 24'h000000, touched_q);
  endtask
  // Clock enable low freezes the block: no burst and no read answer.
  task t_freeze;
    clk_en = 1'b0;
    rd_req = 1'b1;
    rd_first = 1'b1;
    rd_addr = 4'h0;
    @(negedge clk_sys);
    snap = req_rises;
    repeat (60) @(negedge clk_sys);
    chk_bit("frozen rd_valid", 1'b0, rd_valid_q);
    chk_vec("frozen bursts", snap[23:0], req_rises[23:0]);
    clk_en = 1'b1;
    rd(1'b1, 4'h0, 8'h00);
    rd_req = 1'b0;
    repeat (60) @(negedge clk_sys);
    chk_bit("bursts resumed", 1'b1, req_rises > snap);
  endtask
  task t_selftest;
    fault_in = 1'b1;
    repeat (3) wait_scan;
    chk_vec("fault", 24'h000003, fault_q);
    chk_bit("fmea_err", 1'b1, fmea_err_q);
    fault_in = 1'b0;
    repeat (3) wait_scan;
    chk_vec("fault", 24'h000000, fault_q);
    level = 16'h0050;
    repeat (2) wait_scan;
    chk_vec("lsl", 24'h000003, lsl_q);
    chk_bit("lsl_err", 1'b1, lsl_err_q);
    level = 16'h0200;
    repeat (2) wait_scan;
    chk_vec("lsl", 24'h000000, lsl_q);
  endtask
  task t_sleep;
    sleep_enable = 1'b1;
    key_calibrating = 24'h000002;
    repeat (3) wait_scan;
    chk_bit("asleep", 1'b0, asleep_q);
    key_calibrating = 24'h000000;
    comm_active = 1'b1;
    repeat (3) wait_scan;
    chk_bit("asleep", 1'b0, asleep_q);
    comm_active = 1'b0;
    wait_sleep;
    n = 0;
    while (asleep_q === 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n = n + 1;
    end
    chk_bit("wake time", 1'b1, n >= 7 && n <= 10);
    n = 0;
    while (!(acq_req_q && acq_test_q) && asleep_q !== 1'b1 && n < 400) begin
      @(negedge clk_sys);
      n = n + 1;
    end
    chk_bit("full scan", 1'b0, asleep_q);
    chk_bit("scan after wake", 1'b1, acq_req_q && acq_test_q);
    wait_sleep;
    @(negedge clk_sys);
    chk_bit("drift_run", 1'b0, drift_run_q);
    comm_start = 1'b1;
    @(negedge clk_sys);
    comm_start = 1'b0;
    chk_bit("comm wake", 1'b0, asleep_q);
    wait_sleep;
    sleep_enable = 1'b0;
    repeat (3) wait_scan;
    chk_bit("asleep", 1'b0, asleep_q);
  endtask
  task test_done;
    $display("mismatches=%0d check_count=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog sized well beyond the expected run of about a thousand cycles.
  initial begin
    #(100 * 30000);
    mismatches = mismatches + 1;
    test_done;
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    t_confirm;
    t_read;
    t_freeze;
    t_selftest;
    t_sleep;
    test_done;
  end
endmodule // testbench
